// [hdl/status_word_pkg.sv]
// Constants for the processor status word: field positions, reset value,
// register offsets and the operation classes of the execution logic.
// Assumes a 9-bit data-memory address with 128 locations per bank.
package status_word_pkg;

    // ==========================================================
    // Address map
    // ==========================================================
    localparam int ADDR_W = 9;
    localparam int OFS_W = 7;
    localparam logic [OFS_W-1:0] STAT_OFS = 7'h03;
    localparam logic [ADDR_W-1:0] EVT_ADDR = 9'h07e;
    localparam logic [ADDR_W-1:0] MASK_ADDR = 9'h07f;

    // ==========================================================
    // Field layout of the status word
    // ==========================================================
    localparam int IND_BIT = 7;
    localparam int BANK_HI = 6;
    localparam int BANK_LO = 5;
    localparam int WDX_BIT = 4;
    localparam int SLP_BIT = 3;
    localparam int ZERO_BIT = 2;
    localparam int DIG_BIT = 1;
    localparam int CRY_BIT = 0;
    localparam logic [7:0] STAT_RESET = 8'h18;
    localparam logic [7:0] STAT_WR_MASK = 8'he7;

    // ==========================================================
    // Event bits and operation classes
    // ==========================================================
    localparam int EVT_W = 2;
    localparam int EVT_WDX = 0;
    localparam int EVT_SLP = 1;
    localparam logic [2:0] OP_NONE = 3'h0;
    localparam logic [2:0] OP_ADD = 3'h1;
    localparam logic [2:0] OP_SUB = 3'h2;
    localparam logic [2:0] OP_LOGIC = 3'h3;
    localparam logic [2:0] OP_ZERO_FILE = 3'h4;
    localparam logic [2:0] OP_KICK = 3'h5;
    localparam logic [2:0] OP_SLEEP = 3'h6;

endpackage

// [hdl/cpu_status_flag_register.sv]
// Processor status word of a small core, with its flag update logic.
// Assumes the execution logic presents each instruction for one clock:
// its operation class, operands and any file write, all in the same cycle.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module cpu_status_flag_register
    import status_word_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [2:0] op_i,
    input wire logic [7:0] operand_w_i,
    input wire logic [7:0] operand_f_i,
    input wire logic [7:0] logic_result_i,
    input wire logic wdt_timeout_i,
    output logic [7:0] rdata_o,
    output logic [7:0] status_o,
    output logic indirect_bank_hi_o,
    output logic [1:0] direct_bank_sel_o,
    output logic irq_o
);

    // ==========================================================
    // Flag arithmetic
    // ==========================================================
    // Returns {carry, digit carry, result}. Subtraction adds the two's
    // complement of W, so both carries come out as active-low borrows.
    function automatic logic [9:0] alu_flags(input logic [7:0] w, input logic [7:0] f,
                                             input logic sub);
        logic [7:0] wx;
        logic [8:0] full;
        logic [4:0] low;
        wx = sub ? ~w : w;
        full = {1'b0, f} + {1'b0, wx} + {8'h00, sub};
        low = {1'b0, f[3:0]} + {1'b0, wx[3:0]} + {4'h0, sub};
        return {full[8], low[4], full[7:0]};
    endfunction

    logic [7:0] stat_r;
    logic [7:0] stat_nxt;
    logic [EVT_W-1:0] evt_r;
    logic [EVT_W-1:0] evt_nxt;
    logic [EVT_W-1:0] mask_r;
    logic [EVT_W-1:0] mask_nxt;
    logic [9:0] arith;
    logic arith_op;
    logic stat_hit;
    logic stat_wr;
    logic flag_op;
    logic evt_rd;
    logic [7:0] wr_val;

    // ==========================================================
    // Decode
    // ==========================================================
    // Only the in-bank offset is compared, so every bank aliases here.
    // bank-free decode
    assign stat_hit = (addr_i[OFS_W-1:0] == STAT_OFS);
    assign stat_wr = wr_i && stat_hit;
    assign evt_rd = rd_i && (addr_i == EVT_ADDR);
    assign arith_op = (op_i == OP_ADD) || (op_i == OP_SUB);
    // Bit clear, bit set, swap and move decode as no class, so no flag result or flag lock applies to them.
    // flag-touching classes only
    assign flag_op = arith_op || (op_i == OP_LOGIC) || (op_i == OP_ZERO_FILE);
    assign arith = alu_flags(operand_w_i, operand_f_i, op_i == OP_SUB);
    assign wr_val = (op_i == OP_ZERO_FILE) ? 8'h00 : wdata_i;

    // ==========================================================
    // Next status word
    // ==========================================================
    // Order matters: the file write first, flag results over it, then
    // the reset-cause events, with a watchdog time-out last so that it
    // is never lost to a kick or sleep in the same cycle.
    always_comb begin
        stat_nxt = stat_r;
        if (stat_wr) begin
            stat_nxt = (wr_val & STAT_WR_MASK) | (stat_r & ~STAT_WR_MASK);
        end
        // A flag-touching instruction aimed at the status word loses its data for all
        // three flag bits; otherwise a logic op or a file clear would clobber the carries.
        // flag bits write-locked
        if (stat_wr && flag_op) begin
            stat_nxt[ZERO_BIT] = stat_r[ZERO_BIT];
            stat_nxt[DIG_BIT] = stat_r[DIG_BIT];
            stat_nxt[CRY_BIT] = stat_r[CRY_BIT];
        end
        if (arith_op) begin
            stat_nxt[ZERO_BIT] = (arith[7:0] == 8'h00);
            stat_nxt[DIG_BIT] = arith[8];
            stat_nxt[CRY_BIT] = arith[9];
        end
        if (op_i == OP_LOGIC) begin
            stat_nxt[ZERO_BIT] = (logic_result_i == 8'h00);
        end
        if (op_i == OP_ZERO_FILE) begin
            stat_nxt[ZERO_BIT] = 1'b1;
        end
        if (op_i == OP_KICK) begin
            stat_nxt[WDX_BIT] = 1'b1;
            stat_nxt[SLP_BIT] = 1'b1;
        end
        if (op_i == OP_SLEEP) begin
            stat_nxt[WDX_BIT] = 1'b1;
            stat_nxt[SLP_BIT] = 1'b0;
        end
        if (wdt_timeout_i) begin
            stat_nxt[WDX_BIT] = 1'b0;
        end
    end

    // ==========================================================
    // Status word and bank outputs
    // ==========================================================
    // Bank outputs come from the register, so a write shows up only after
    // the edge that ends the writing instruction.
    // bank change next instruction
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            stat_r <= STAT_RESET;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    assign status_o = stat_r;
    assign indirect_bank_hi_o = stat_r[IND_BIT];
    assign direct_bank_sel_o = stat_r[BANK_HI:BANK_LO];

    // ==========================================================
    // Event status, mask and interrupt
    // ==========================================================
    // A read clears the events it returned; an event in that very cycle
    // sets the bit again, so it is not lost.
    always_comb begin
        evt_nxt = evt_r & ~(evt_rd ? evt_r : {EVT_W{1'b0}});
        evt_nxt[EVT_WDX] = evt_nxt[EVT_WDX] | wdt_timeout_i;
        evt_nxt[EVT_SLP] = evt_nxt[EVT_SLP] | (op_i == OP_SLEEP);
        mask_nxt = mask_r;
        if (wr_i && (addr_i == MASK_ADDR)) begin
            mask_nxt = wdata_i[EVT_W-1:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            evt_r <= '0;
            mask_r <= '0;
        end else begin
            evt_r <= evt_nxt;
            mask_r <= mask_nxt;
        end
    end

    // Registered from the next values so the line tracks the bits exactly.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(evt_nxt & mask_nxt);
        end
    end

    // ==========================================================
    // Read port
    // ==========================================================
    // Data appear the cycle after the strobe; unmapped addresses read zero.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i && stat_hit) begin
            rdata_o <= stat_r;
        end else if (evt_rd) begin
            rdata_o <= {{(8-EVT_W){1'b0}}, evt_r};
        end else if (rd_i && (addr_i == MASK_ADDR)) begin
            rdata_o <= {{(8-EVT_W){1'b0}}, mask_r};
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    sequence s_stat_write;
        wr_i && stat_hit;
    endsequence

    sequence s_plain_cycle;
        op_i == OP_NONE && !wdt_timeout_i;
    endsequence

    property p_write_lands;
        @(posedge clock_i) disable iff (sys_rst_i)
        (s_stat_write and s_plain_cycle) |=>
            (stat_r & STAT_WR_MASK) == ($past(wdata_i) & STAT_WR_MASK);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("status write not stored");

    property p_flag_override;
        @(posedge clock_i) disable iff (sys_rst_i)
        (s_stat_write and arith_op) |=> stat_r[2:0] ==
            {$past(arith[7:0]) == 8'h00, $past(arith[8]), $past(arith[9])};
    endproperty
    a_flag_override: assert property (p_flag_override) else $error("flags took write data");

    property p_protected;
        @(posedge clock_i) disable iff (sys_rst_i)
        (s_stat_write and s_plain_cycle) |=> $stable(stat_r[WDX_BIT:SLP_BIT]);
    endproperty
    a_protected: assert property (p_protected) else $error("write changed reset-cause bits");

    property p_zero_file;
        @(posedge clock_i) disable iff (sys_rst_i)
        (s_stat_write and op_i == OP_ZERO_FILE and !wdt_timeout_i) |=>
            stat_r[7:5] == 3'h0 && stat_r[ZERO_BIT] &&
            stat_r[4:3] == $past(stat_r[4:3]) && stat_r[1:0] == $past(stat_r[1:0]);
    endproperty
    a_zero_file: assert property (p_zero_file) else $error("file clear of status wrong");

    property p_plain_keeps;
        @(posedge clock_i) disable iff (sys_rst_i)
        s_plain_cycle |=> stat_r[2:0] == ($past(stat_wr) ? $past(wdata_i[2:0]) : $past(stat_r[2:0]));
    endproperty
    a_plain_keeps: assert property (p_plain_keeps) else $error("plain op changed a flag");

    property p_borrow;
        @(posedge clock_i) disable iff (sys_rst_i)
        op_i == OP_SUB |=> stat_r[CRY_BIT] == ($past(operand_f_i) >= $past(operand_w_i));
    endproperty
    a_borrow: assert property (p_borrow) else $error("borrow polarity wrong");

    property p_indirect;
        @(posedge clock_i) disable iff (sys_rst_i)
        s_stat_write |=> indirect_bank_hi_o == $past(wr_val[IND_BIT]);
    endproperty
    a_indirect: assert property (p_indirect) else $error("indirect half select wrong");

    property p_direct;
        @(posedge clock_i) disable iff (sys_rst_i)
        s_stat_write |=> direct_bank_sel_o == $past(wr_val[BANK_HI:BANK_LO]);
    endproperty
    a_direct: assert property (p_direct) else $error("direct bank select wrong");

    property p_timeout;
        @(posedge clock_i) disable iff (sys_rst_i)
        wdt_timeout_i |=> !stat_r[WDX_BIT];
    endproperty
    a_timeout: assert property (p_timeout) else $error("time-out bit not cleared");

    property p_sleep;
        @(posedge clock_i) disable iff (sys_rst_i)
        (op_i == OP_SLEEP && !wdt_timeout_i) |=> !stat_r[SLP_BIT] && stat_r[WDX_BIT];
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep did not update bits");

    property p_logic_zero;
        @(posedge clock_i) disable iff (sys_rst_i)
        op_i == OP_LOGIC |=> stat_r[ZERO_BIT] == ($past(logic_result_i) == 8'h00);
    endproperty
    a_logic_zero: assert property (p_logic_zero) else $error("zero flag wrong");

    property p_digit;
        @(posedge clock_i) disable iff (sys_rst_i)
        op_i == OP_ADD |=> stat_r[DIG_BIT] ==
            ((5'($past(operand_f_i[3:0])) + 5'($past(operand_w_i[3:0]))) > 5'h0f);
    endproperty
    a_digit: assert property (p_digit) else $error("digit carry wrong");

    property p_carry;
        @(posedge clock_i) disable iff (sys_rst_i)
        op_i == OP_ADD |=> stat_r[CRY_BIT] ==
            ((9'($past(operand_f_i)) + 9'($past(operand_w_i))) > 9'h0ff);
    endproperty
    a_carry: assert property (p_carry) else $error("carry wrong");

    property p_alias;
        @(posedge clock_i) disable iff (sys_rst_i)
        (wr_i && addr_i[OFS_W-1:0] == STAT_OFS && op_i == OP_NONE) |=>
            stat_r[7:5] == $past(wdata_i[7:5]);
    endproperty
    a_alias: assert property (p_alias) else $error("status alias missed");

    // Bank outputs may move only at the edge that ends a status write.
    // bank holds in write cycle
    property p_bank_late;
        @(posedge clock_i) disable iff (sys_rst_i)
        !stat_wr |=> $stable(direct_bank_sel_o) && $stable(indirect_bank_hi_o);
    endproperty
    a_bank_late: assert property (p_bank_late) else $error("bank change timing wrong");

    property p_flag_lock;
        @(posedge clock_i) disable iff (sys_rst_i)
        (s_stat_write and op_i == OP_LOGIC) |=>
            stat_r[DIG_BIT:CRY_BIT] == $past(stat_r[DIG_BIT:CRY_BIT]);
    endproperty
    a_flag_lock: assert property (p_flag_lock) else $error("logic op wrote the carries");

    property p_kick;
        @(posedge clock_i) disable iff (sys_rst_i)
        (op_i == OP_KICK && !wdt_timeout_i) |=> stat_r[WDX_BIT] && stat_r[SLP_BIT];
    endproperty
    a_kick: assert property (p_kick) else $error("kick did not set cause bits");

endmodule

// [tb/exec_unit_model.sv]
// Behavioural model of the instruction execution logic that drives the status word.
// Assumes one clock; each instruction is presented for exactly one cycle.
`timescale 1ns/1ps
module exec_unit_model
    import status_word_pkg::*;
(
    input wire logic clock_i,
    output logic [ADDR_W-1:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    output logic [2:0] op_o,
    output logic [7:0] operand_w_o,
    output logic [7:0] operand_f_o,
    output logic [7:0] logic_result_o,
    output logic wdt_timeout_o
);
    // ==========================================================
    // Idle state at time zero
    // ==========================================================
    // Everything starts quiet so the first edge after reset sees no request.
    initial begin
        addr_o = '0;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        op_o = OP_NONE;
        operand_w_o = 8'h00;
        operand_f_o = 8'h00;
        logic_result_o = 8'h00;
        wdt_timeout_o = 1'b0;
    end

    // ==========================================================
    // One instruction cycle
    // ==========================================================
    // Drives one instruction for a single cycle, then releases it. Released data lines
    // carry the inverse of their last value so a stale word can never look valid.
    task automatic step(input logic [2:0] op, input logic [7:0] w, input logic [7:0] f,
                        input logic [7:0] lres, input logic wr, input logic rd, input logic wdt,
                        input logic [ADDR_W-1:0] addr, input logic [7:0] wd);
        @(posedge clock_i);
        op_o <= op;
        operand_w_o <= w;
        operand_f_o <= f;
        logic_result_o <= lres;
        wr_o <= wr;
        rd_o <= rd;
        wdt_timeout_o <= wdt;
        addr_o <= addr;
        wdata_o <= wd;
        @(posedge clock_i);
        op_o <= OP_NONE;
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        wdt_timeout_o <= 1'b0;
        addr_o <= ~addr;
        wdata_o <= ~wd;
        operand_w_o <= ~w;
        operand_f_o <= ~f;
        logic_result_o <= ~lres;
    endtask
endmodule

// [tb/test_cpu_status_flag_register.sv]
// Self-checking bench for the processor status word.
// Assumes the execution model drives every functional input; the bench owns clock and reset.
`timescale 1ns/1ps
module test_cpu_status_flag_register
    import status_word_pkg::*;
;
    logic clock_i, sys_rst_i, wr_i, rd_i, wdt_timeout_i, indirect_bank_hi_o, irq_o;
    logic [ADDR_W-1:0] addr_i;
    logic [7:0] wdata_i, operand_w_i, operand_f_i, logic_result_i, rdata_o, status_o;
    logic [2:0] op_i;
    logic [1:0] direct_bank_sel_o;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;

    cpu_status_flag_register i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .op_i(op_i), .operand_w_i(operand_w_i),
        .operand_f_i(operand_f_i), .logic_result_i(logic_result_i), .wdt_timeout_i(wdt_timeout_i),
        .rdata_o(rdata_o), .status_o(status_o), .indirect_bank_hi_o(indirect_bank_hi_o),
        .direct_bank_sel_o(direct_bank_sel_o), .irq_o(irq_o));
    exec_unit_model i_exec (.clock_i(clock_i), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i),
        .rd_o(rd_i), .op_o(op_i), .operand_w_o(operand_w_i), .operand_f_o(operand_f_i),
        .logic_result_o(logic_result_i), .wdt_timeout_o(wdt_timeout_i));

    // ==========================================================
    // Clock, reset and hang guard
    // ==========================================================
    // 200 MHz clock; the run needs well under a thousand cycles, so 3000 means a hang.
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            wrap_up();
        end
    end

    // ==========================================================
    // Shared helpers
    // ==========================================================
    // Compares one byte; case inequality keeps unknowns from passing.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask
    // File write with an optional operation class in the same instruction.
    task automatic fw(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [2:0] op = OP_NONE);
        i_exec.step(op, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0, a, d);
        #1;
    endtask
    // Read data stand only in the cycle after the strobe, so look there.
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        i_exec.step(OP_NONE, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1, 1'b0, a, 8'h00);
        #1;
        chk(rdata_o, exp);
    endtask
    // Pure operation without a file access.
    task automatic op_only(input logic [2:0] op, input logic [7:0] lres, input logic wdt);
        i_exec.step(op, 8'h00, 8'h00, lres, 1'b0, 1'b0, wdt, 9'h000, 8'h00);
        #1;
    endtask
    // Interrupt is registered; give it two edges to settle.
    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge clock_i);
        #1;
        chk({7'h00, irq_o}, {7'h00, exp});
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset();
        chk(status_o, 8'h18);
        chk({7'h00, irq_o}, 8'h00);
    endtask
    // Each bank reaches the word at the same offset; bits 4:3 written as zero must stay set.
    task automatic t_banks();
        logic [1:0] bk;
        for (int b = 0; b < 4; b++) begin
            bk = b[1:0];
            fw({bk, 7'h03}, {bk[1], bk, 5'b00101});
            chk(status_o, {bk[1], bk, 5'b11101});
            chk({6'h00, direct_bank_sel_o}, {6'h00, bk});
            chk({7'h00, indirect_bank_hi_o}, {7'h00, bk[1]});
        end
    endtask
    // Add and subtract while writing the inverse flags: the results must win.
    task automatic t_arith();
        logic [2:0] ops [6] = '{OP_ADD, OP_ADD, OP_ADD, OP_SUB, OP_SUB, OP_SUB};
        logic [7:0] ws [6] = '{8'h0f, 8'hff, 8'h80, 8'h01, 8'h01, 8'h01};
        logic [7:0] fs [6] = '{8'h01, 8'h01, 8'h80, 8'h01, 8'h00, 8'h10};
        logic [2:0] es [6] = '{3'h2, 3'h7, 3'h5, 3'h7, 3'h0, 3'h1};
        for (int i = 0; i < 6; i++) begin
            i_exec.step(ops[i], ws[i], fs[i], 8'h00, 1'b1, 1'b0, 1'b0, 9'h083, {5'h00, ~es[i]});
            #1;
            chk(status_o, {5'h03, es[i]});
        end
    endtask
    // Logic ops touch zero only; a plain move writes every writable bit.
    task automatic t_logic();
        op_only(OP_LOGIC, 8'h00, 1'b0);
        chk(status_o, 8'h1d);
        op_only(OP_LOGIC, 8'h5a, 1'b0);
        chk(status_o, 8'h19);
        fw(9'h103, 8'h06, 3'h7);
        chk(status_o, 8'h1e);
        // A logic op written to the word: zero from the result, both carries kept.
        i_exec.step(OP_LOGIC, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0, 9'h003, 8'he0);
        #1;
        chk(status_o, 8'hfe);
    endtask
    task automatic t_clear();
        fw(9'h183, 8'he2);
        chk(status_o, 8'hfa);
        fw(9'h003, 8'h5a, OP_ZERO_FILE);
        chk(status_o, 8'h1e);
    endtask
    // Reset-cause events, sticky status, masking and read-to-clear.
    task automatic t_events();
        fw(MASK_ADDR, 8'h03);
        rd_chk(MASK_ADDR, 8'h03);
        op_only(OP_NONE, 8'h00, 1'b1);
        chk(status_o, 8'h0e);
        irq_chk(1'b1);
        fw(9'h003, 8'h18);
        chk(status_o, 8'h08);
        rd_chk(EVT_ADDR, 8'h01);
        irq_chk(1'b0);
        op_only(OP_SLEEP, 8'h00, 1'b0);
        chk(status_o, 8'h10);
        irq_chk(1'b1);
        rd_chk(EVT_ADDR, 8'h02);
        op_only(OP_KICK, 8'h00, 1'b0);
        chk(status_o, 8'h18);
        fw(MASK_ADDR, 8'h00);
        op_only(OP_NONE, 8'h00, 1'b1);
        chk(status_o, 8'h08);
        irq_chk(1'b0);
        rd_chk(EVT_ADDR, 8'h01);
        rd_chk(9'h050, 8'h00);
    endtask

    // ==========================================================
    // Verdict and main sequence
    // ==========================================================
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        sys_rst_i = 1'b1;
        repeat (3) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        #1;
        t_reset();
        t_banks();
        fw(9'h003, 8'h00);
        t_arith();
        t_logic();
        t_clear();
        t_events();
        wrap_up();
    end
endmodule
